/* File: scdl_pkg.sv */
// shared constants, types and helpers for the six-channel column loader
package scdl_pkg;
   localparam int NUM_CHAN = 6;
   localparam int CODE_W = 10;
   localparam int LEVEL_W = 11;
   localparam int PIN_W = 17;
   localparam logic [9:0] CODE_MAX = 10'h3FF;
   localparam logic [9:0] CODE_RESET = 10'h000;
   localparam logic [2:0] STEP_FIRST = 3'h0;
   localparam logic [2:0] STEP_LAST = 3'h5;
   localparam logic [2:0] CHAN_TOP = 3'h5;

   // pin vector bit positions after synchronising
   localparam int PIN_CLK = 0;
   localparam int PIN_START = 1;
   localparam int PIN_EDGE = 2;
   localparam int PIN_DIR = 3;
   localparam int PIN_XFER = 4;
   localparam int PIN_POL = 5;
   localparam int PIN_STANDBY = 6;
   localparam int PIN_WORD_LSB = 7;

   // register byte offsets
   localparam int ADDR_W = 5;
   localparam logic [4:0] REG_CTRL = 5'h00;
   localparam logic [4:0] REG_STATUS = 5'h04;
   localparam logic [4:0] REG_CODE0 = 5'h08;
   localparam logic [4:0] REG_CODE5 = 5'h1C;

   // control register fields
   localparam int CTRL_SOFT_STANDBY = 0;
   localparam int CTRL_LOAD_ENABLE = 1;
   localparam logic [1:0] CTRL_RESET = 2'h2;

   // status register fields
   localparam int STAT_BUSY = 0;
   localparam int STAT_XFER_PEND = 1;
   localparam int STAT_STANDBY = 2;
   localparam int STAT_DIR = 3;
   localparam int STAT_EDGE = 4;
   localparam int STAT_POL = 5;
   localparam int STAT_START_SEEN = 6;
   localparam int STAT_STEP_LSB = 8;

   typedef logic [9:0] scdl_code_t;
   typedef scdl_code_t [5:0] scdl_bank_t;
   typedef logic signed [10:0] scdl_level_t;
   typedef scdl_level_t [5:0] scdl_levels_t;

   // channel filled at a given step of a sequence
   function automatic logic [2:0] scdl_chan_index(input logic up, input logic [2:0] step);
      scdl_chan_index = up ? step : 3'(CHAN_TOP - step);
   endfunction : scdl_chan_index

   // signed drive level relative to the mid reference, in code steps
   function automatic scdl_level_t scdl_drive_level(input scdl_code_t code, input logic above);
      logic [10:0] mag;
      mag = {1'b0, 10'(CODE_MAX - code)};
      scdl_drive_level = above ? $signed(mag) : -$signed(mag);
   endfunction : scdl_drive_level
endpackage : scdl_pkg

/* File: scdl_sync.sv */
// two-stage synchroniser for the panel-side pins
`timescale 1ns/10ps
`default_nettype none
module scdl_sync #(
   parameter int W = 1
) (
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);
   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] sync_q;
   logic [W-1:0] sync_d;

   always_comb begin
      meta_d = i_async;
      sync_d = meta_q;
   end

   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign o_sync = sync_q;
endmodule : scdl_sync
`default_nettype wire

/* File: scdl_avs.sv */
// avalon-mm register slave: control, status and output code readback
`timescale 1ns/10ps
`default_nettype none
module scdl_avs
   import scdl_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   input wire logic [scdl_pkg::ADDR_W-1:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic [31:0] i_status,
   input wire scdl_pkg::scdl_bank_t i_out_bank,
   output logic o_soft_standby,
   output logic o_load_enable
);
   import scdl_pkg::*;

   logic ack_q;
   logic ack_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic [1:0] ctrl_q;
   logic [1:0] ctrl_d;
   logic req;
   logic [2:0] code_sel;

   assign req = i_avs_read | i_avs_write;
   assign code_sel = 3'((i_avs_address - REG_CODE0) >> 2);

   always_comb begin
      ack_d = req & ~ack_q;
      rdata_d = rdata_q;
      ctrl_d = ctrl_q;
      if (req && !ack_q) begin
         rdata_d = 32'h0000_0000;
         if (i_avs_address == REG_CTRL) begin
            rdata_d = {30'h0, ctrl_q};
         end else if (i_avs_address == REG_STATUS) begin
            rdata_d = i_status;
         end else if (i_avs_address >= REG_CODE0 && i_avs_address <= REG_CODE5
                      && i_avs_address[1:0] == 2'h0) begin
            rdata_d = {22'h0, i_out_bank[code_sel]};
         end
      end
      // write lands on the edge where waitrequest is low
      if (i_avs_write && ack_q && i_avs_address == REG_CTRL && i_avs_byteenable[0]) begin
         ctrl_d = i_avs_writedata[1:0];
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ack_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         ctrl_q <= CTRL_RESET;
      end else begin
         ack_q <= ack_d;
         rdata_q <= rdata_d;
         ctrl_q <= ctrl_d;
      end
   end

   assign o_avs_waitrequest = req & ~ack_q;
   assign o_avs_readdata = rdata_q;
   assign o_soft_standby = ctrl_q[CTRL_SOFT_STANDBY];
   assign o_load_enable = ctrl_q[CTRL_LOAD_ENABLE];
endmodule : scdl_avs
`default_nettype wire

/* File: scdl_loader.sv */
// six-channel column converter loader: sequential word capture and output transfer
//
// Function
// [R1] A valid start request launches a six-edge loading cycle filling the six channel latches.
// [R2] A sequence begins on an active edge only if the start input was high at the previous one.
// [R3] Edge select high uses rising panel-clock edges, low uses falling edges, for data and start.
// [R4] Direction high fills channel 0 up to 5, low fills channel 5 down to 0.
// [R5] Transfer high on a rising edge copies all six latches to the outputs on the next falling edge.
// [R6] Standby high clears all stored channel data and holds the loader idle.
// [R7] Standby low returns the loader to normal loading and transfer.
// [R8] All six channels are loaded from one shared ten-bit word bus.
// [R9] Polarity low maps code 0 to mid minus full scale rising to mid at code 1023.
// [R10] Polarity high maps the lowest code to mid plus full scale falling to mid.
// [R11] The word bus is ten bits with bit 9 the most significant.
// [R12] After the sixth word, further words are ignored until a new start request.
// [R13] Output latches hold their codes during loading until the next transfer.
//
// Implementation choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module scdl_loader
   import scdl_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   input wire logic [scdl_pkg::ADDR_W-1:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic i_panel_clk,
   input wire logic i_sequence_start,
   input wire logic i_edge_select,
   input wire logic i_load_direction,
   input wire logic i_output_transfer,
   input wire logic i_polarity_invert,
   input wire logic i_standby_request,
   input wire logic [9:0] i_input_word_bus,
   output scdl_pkg::scdl_bank_t o_chan_code,
   output scdl_pkg::scdl_levels_t o_chan_level,
   output logic o_above_mid,
   output logic o_standby_active,
   output logic o_loading
);
   import scdl_pkg::*;

   // sequencer phases
   typedef enum logic {
      SEQ_IDLE,
      SEQ_LOAD
   } scdl_seq_e;

   // synchronised pin image
   logic [PIN_W-1:0] pin_raw;
   logic [PIN_W-1:0] pin_s;
   logic pclk_s;
   logic start_s;
   logic edge_s;
   logic dir_s;
   logic xfer_s;
   logic pol_s;
   logic standby_pin_s;
   scdl_code_t word_s;

   // software controls
   logic soft_standby;
   logic load_enable;
   logic standby;

   // panel clock edge detection
   logic pclk_prev_q;
   logic pclk_prev_d;
   logic pclk_rise;
   logic pclk_fall;
   logic active_edge;

   // loading sequence state
   logic start_seen_q;
   logic start_seen_d;
   scdl_seq_e seq_q;
   scdl_seq_e seq_d;
   logic busy;
   logic dir_q;
   logic dir_d;
   logic [2:0] step_q;
   logic [2:0] step_d;
   scdl_bank_t in_bank_q;
   scdl_bank_t in_bank_d;

   // transfer and output state
   logic xfer_pend_q;
   logic xfer_pend_d;
   scdl_bank_t out_bank_q;
   scdl_bank_t out_bank_d;
   scdl_levels_t level_q;
   scdl_levels_t level_d;
   logic above_q;
   logic above_d;

   logic [31:0] status;

   // pins cross into the system clock domain
   assign pin_raw = {i_input_word_bus, i_standby_request, i_polarity_invert,
                     i_output_transfer, i_load_direction, i_edge_select,
                     i_sequence_start, i_panel_clk};

   scdl_sync #(
      .W(PIN_W)
   ) u_pin_sync (
      .i_sys_clk(i_sys_clk),
      .i_sys_rst(i_sys_rst),
      .i_async(pin_raw),
      .o_sync(pin_s)
   );

   assign pclk_s = pin_s[PIN_CLK];
   assign start_s = pin_s[PIN_START];
   assign edge_s = pin_s[PIN_EDGE];
   assign dir_s = pin_s[PIN_DIR];
   assign xfer_s = pin_s[PIN_XFER];
   assign pol_s = pin_s[PIN_POL];
   assign standby_pin_s = pin_s[PIN_STANDBY];
   assign word_s = pin_s[PIN_WORD_LSB +: CODE_W]; // [R8] [R11]

   assign standby = standby_pin_s | soft_standby;

   // edge detection on the synchronised panel clock
   always_comb begin
      pclk_prev_d = pclk_s;
   end

   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         pclk_prev_q <= 1'b0;
      end else begin
         pclk_prev_q <= pclk_prev_d;
      end
   end

   assign pclk_rise = pclk_s & ~pclk_prev_q;
   assign pclk_fall = ~pclk_s & pclk_prev_q;
   assign active_edge = edge_s ? pclk_rise : pclk_fall; // [R3]

   // loading sequencer
   always_comb begin
      logic [2:0] idx;
      logic [2:0] cur_step;
      logic cur_dir;
      logic take;
      idx = 3'h0;
      cur_step = step_q;
      cur_dir = dir_q;
      take = 1'b0;
      start_seen_d = start_seen_q;
      seq_d = seq_q;
      dir_d = dir_q;
      step_d = step_q;
      in_bank_d = in_bank_q;
      if (standby) begin
         // debiased: stored data is lost
         start_seen_d = 1'b0; // [R6]
         seq_d = SEQ_IDLE;
         step_d = STEP_FIRST;
         dir_d = 1'b0;
         in_bank_d = '{default: CODE_RESET}; // [R6]
      end else if (active_edge && load_enable) begin // [R7]
         start_seen_d = start_s; // [R2] [R3]
         // words taken inside a sequence or on its first edge
         case (seq_q)
            SEQ_IDLE: begin
               take = start_seen_q; // [R12]
            end
            SEQ_LOAD: begin
               take = 1'b1;
            end
            default: begin
               take = 1'b0;
            end
         endcase
         if (start_seen_q) begin
            // new sequence starts on this edge, even mid-sequence
            cur_step = STEP_FIRST; // [R2]
            cur_dir = dir_s;
         end
         if (take) begin // [R12]
            idx = scdl_chan_index(cur_dir, cur_step); // [R4]
            in_bank_d[idx] = word_s; // [R1] [R8]
            dir_d = cur_dir;
            step_d = 3'(cur_step + 3'h1);
            // last step drops back to idle
            seq_d = (cur_step != STEP_LAST) ? SEQ_LOAD : SEQ_IDLE; // [R1] [R12]
         end
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         start_seen_q <= 1'b0;
         seq_q <= SEQ_IDLE;
         dir_q <= 1'b0;
         step_q <= STEP_FIRST;
         in_bank_q <= '{default: CODE_RESET};
      end else begin
         start_seen_q <= start_seen_d;
         seq_q <= seq_d;
         dir_q <= dir_d;
         step_q <= step_d;
         in_bank_q <= in_bank_d;
      end
   end

   assign busy = (seq_q == SEQ_LOAD);

   // output transfer
   always_comb begin
      xfer_pend_d = xfer_pend_q;
      out_bank_d = out_bank_q;
      if (standby) begin
         xfer_pend_d = 1'b0;
         out_bank_d = '{default: CODE_RESET}; // [R6]
      end else begin
         if (pclk_rise && xfer_s) begin
            xfer_pend_d = 1'b1; // [R5]
         end
         if (pclk_fall && xfer_pend_q) begin
            // all six move together; otherwise held
            out_bank_d = in_bank_q; // [R5] [R13]
            xfer_pend_d = 1'b0;
         end
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         xfer_pend_q <= 1'b0;
         out_bank_q <= '{default: CODE_RESET};
      end else begin
         xfer_pend_q <= xfer_pend_d;
         out_bank_q <= out_bank_d;
      end
   end

   // drive levels follow the output latches one cycle later
   always_comb begin
      above_d = pol_s; // [R10]
      for (int i = 0; i < NUM_CHAN; i++) begin
         level_d[i] = scdl_drive_level(out_bank_q[i], pol_s); // [R9] [R10]
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         level_q <= '{default: 11'sh000};
         above_q <= 1'b0;
      end else begin
         level_q <= level_d;
         above_q <= above_d;
      end
   end

   // status word for software
   always_comb begin
      status = 32'h0000_0000;
      status[STAT_BUSY] = busy;
      status[STAT_XFER_PEND] = xfer_pend_q;
      status[STAT_STANDBY] = standby;
      status[STAT_DIR] = dir_q;
      status[STAT_EDGE] = edge_s;
      status[STAT_POL] = pol_s;
      status[STAT_START_SEEN] = start_seen_q;
      status[STAT_STEP_LSB +: 3] = step_q;
   end

   scdl_avs u_regs (
      .i_sys_clk(i_sys_clk),
      .i_sys_rst(i_sys_rst),
      .i_avs_address(i_avs_address),
      .i_avs_read(i_avs_read),
      .i_avs_write(i_avs_write),
      .i_avs_writedata(i_avs_writedata),
      .i_avs_byteenable(i_avs_byteenable),
      .o_avs_readdata(o_avs_readdata),
      .o_avs_waitrequest(o_avs_waitrequest),
      .i_status(status),
      .i_out_bank(out_bank_q),
      .o_soft_standby(soft_standby),
      .o_load_enable(load_enable)
   );

   assign o_chan_code = out_bank_q;
   assign o_chan_level = level_q;
   assign o_above_mid = above_q;
   assign o_standby_active = standby;
   assign o_loading = busy;
endmodule : scdl_loader
`default_nettype wire

/* File: scdl_loader_checker.sv */
// port assertions for the column loader
`timescale 1ns/10ps
`default_nettype none
module scdl_loader_checker
   import scdl_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   input wire logic [scdl_pkg::ADDR_W-1:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] o_avs_readdata,
   input wire logic o_avs_waitrequest,
   input wire logic i_panel_clk,
   input wire logic i_standby_request,
   input wire scdl_pkg::scdl_bank_t o_chan_code,
   input wire scdl_pkg::scdl_levels_t o_chan_level,
   input wire logic o_above_mid,
   input wire logic o_standby_active,
   input wire logic o_loading
);
   import scdl_pkg::*;

   // code bank as it stood when the read was taken
   scdl_bank_t code_prev_q;

   always_ff @(posedge i_sys_clk) begin
      code_prev_q <= o_chan_code;
   end

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);

   // every channel level matches its code and polarity
   function automatic logic lv_ok(input scdl_bank_t c, input scdl_levels_t l, input logic a);
      logic [10:0] m;
      lv_ok = 1'b1;
      for (int i = 0; i < 6; i++) begin
         m = 11'h3FF - {1'b0, c[i]};
         if (l[i] != (a ? m : -m)) lv_ok = 1'b0;
      end
   endfunction : lv_ok

   a_sby_sync: assert property ($rose(i_standby_request) |-> ##[1:4] o_standby_active)
      else $error("standby pin not taken");
   a_sby_clear: assert property (o_standby_active |-> ##[0:2] (o_chan_code == '0))
      else $error("codes kept in standby");
   a_sby_idle: assert property (o_standby_active |-> ##[0:2] !o_loading)
      else $error("loading in standby");
   a_xfer_fall: assert property ((o_chan_code != $past(o_chan_code)) && !o_standby_active
      |-> !$past(i_panel_clk, 2)) else $error("codes moved without falling edge");
   a_level_map: assert property ($stable(o_chan_code) && $stable(o_above_mid)
      && !$past(i_sys_rst) |-> lv_ok(o_chan_code, o_chan_level, o_above_mid))
      else $error("level does not match code");
   a_bus_first: assert property ($rose(i_avs_read || i_avs_write) |-> o_avs_waitrequest)
      else $error("no wait state");
   a_bus_done: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
      |=> !o_avs_waitrequest) else $error("bus answer late");
   a_bus_unmap: assert property (i_avs_read && !o_avs_waitrequest && i_avs_address[1:0] != 2'h0
      |-> o_avs_readdata == 32'h0) else $error("unaligned read not zero");
   a_code_read: assert property (i_avs_read && !o_avs_waitrequest && i_avs_address[4:3] != 2'h0
      && i_avs_address[1:0] == 2'h0
      |-> o_avs_readdata == {22'h0, code_prev_q[3'(i_avs_address[4:2] - 3'h2)]})
      else $error("code readback wrong");

   c_seq_end: cover property ($fell(o_loading));
   c_standby: cover property ($rose(o_standby_active));
   c_above: cover property (o_above_mid && $changed(o_chan_code));
endmodule : scdl_loader_checker

bind scdl_loader scdl_loader_checker u_chk (.i_sys_clk, .i_sys_rst, .i_avs_address,
   .i_avs_read, .i_avs_write, .o_avs_readdata, .o_avs_waitrequest, .i_panel_clk,
   .i_standby_request, .o_chan_code, .o_chan_level, .o_above_mid, .o_standby_active, .o_loading);
`default_nettype wire

/* File: scdl_proc_model.sv */
// image processor model driving the panel pins
`timescale 1ns/10ps
`default_nettype none
module scdl_proc_model (
   input wire logic i_sys_clk,
   output logic o_panel_clk,
   output logic o_start,
   output logic o_edge,
   output logic o_dir,
   output logic o_xfer,
   output logic o_pol,
   output logic o_standby,
   output logic [9:0] o_word
);
   initial begin
      {o_panel_clk, o_start, o_edge, o_dir, o_xfer, o_pol, o_standby} = 7'h0;
      o_word = 10'h155;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge i_sys_clk);
   endtask : tick
   // one active edge then back to idle, four cycles per level
   task automatic pulse();
      tick(4);
      o_panel_clk <= o_edge;
      tick(4);
      o_panel_clk <= ~o_edge;
   endtask : pulse
   task automatic pins(input logic p, input logic s);
      o_pol <= p;
      o_standby <= s;
      tick(6);
   endtask : pins
   task automatic frame(input logic e, input logic d, input logic [9:0] b);
      o_edge <= e;
      o_dir <= d;
      o_panel_clk <= ~e;
      tick(4);
      o_start <= 1'b1;
      pulse();
      o_start <= 1'b0;
      for (int k = 0; k < 6; k++) begin
         o_word <= b + 10'(k);
         pulse();
      end
      o_word <= ~o_word;
   endtask : frame
   task automatic transfer();
      o_xfer <= 1'b1;
      pulse();
      tick(4);
      o_xfer <= 1'b0;
      if (!o_edge) pulse();
      tick(8);
   endtask : transfer
endmodule : scdl_proc_model
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the column loader
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import scdl_pkg::*;
   logic i_sys_clk, i_sys_rst, avs_read, avs_write, wait_req, pclk, start, edge_sel, dir;
   logic xfer, pol, sby, above, sby_act, loading;
   logic [4:0] avs_addr;
   logic [31:0] avs_wdata, avs_rdata, rd;
   logic [9:0] word;
   scdl_bank_t code;
   scdl_levels_t level;
   int bad_count = 0;
   int cmp_count = 0;

   scdl_loader u_dut (.i_sys_clk, .i_sys_rst, .i_avs_address(avs_addr), .i_avs_read(avs_read),
      .i_avs_write(avs_write), .i_avs_writedata(avs_wdata), .i_avs_byteenable(4'hF),
      .o_avs_readdata(avs_rdata), .o_avs_waitrequest(wait_req), .i_panel_clk(pclk),
      .i_sequence_start(start), .i_edge_select(edge_sel), .i_load_direction(dir),
      .i_output_transfer(xfer), .i_polarity_invert(pol), .i_standby_request(sby),
      .i_input_word_bus(word), .o_chan_code(code), .o_chan_level(level), .o_above_mid(above),
      .o_standby_active(sby_act), .o_loading(loading));
   scdl_proc_model u_proc (.i_sys_clk, .o_panel_clk(pclk), .o_start(start), .o_edge(edge_sel),
      .o_dir(dir), .o_xfer(xfer), .o_pol(pol), .o_standby(sby), .o_word(word));

   initial begin
      i_sys_clk = 1'b0;
      forever #4 i_sys_clk = ~i_sys_clk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      avs_addr <= a;
      avs_wdata <= d;
      avs_read <= ~wr;
      avs_write <= wr;
      @(posedge i_sys_clk);
      while (wait_req !== 1'b0) @(posedge i_sys_clk);
      rd = avs_rdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge i_sys_clk);
   endtask : bus
   task automatic t_frame(input logic e, input logic d, input logic [9:0] b, input logic p);
      scdl_bank_t prev;
      logic [9:0] c;
      logic [10:0] m;
      prev = code;
      u_proc.pins(p, 1'b0);
      u_proc.frame(e, d, b);
      for (int i = 0; i < 3; i++) u_proc.pulse();
      for (int i = 0; i < 6; i++) chk({22'h0, code[i]}, {22'h0, prev[i]});
      u_proc.transfer();
      chk({31'h0, above}, {31'h0, p});
      for (int i = 0; i < 6; i++) begin
         c = b + 10'(d ? i : 5 - i);
         m = 11'h3FF - {1'b0, c};
         chk({22'h0, code[i]}, {22'h0, c});
         chk({21'h0, level[i]}, {21'h0, p ? m : -m});
         bus(1'b0, 5'(8 + 4 * i), 32'h0);
         chk(rd, {22'h0, c});
      end
   endtask : t_frame
   task automatic t_regs();
      bus(1'b0, 5'h00, 32'h0);
      chk(rd, 32'h2);
      bus(1'b0, 5'h01, 32'h0);
      chk(rd, 32'h0);
      bus(1'b1, 5'h00, 32'h0);
      u_proc.frame(1'b1, 1'b1, 10'h300);
      u_proc.transfer();
      for (int i = 0; i < 6; i++) chk({22'h0, code[i]}, {22'h0, 10'h0A5 + 10'(i)});
      bus(1'b1, 5'h00, 32'h3);
      repeat (3) @(posedge i_sys_clk);
      chk({31'h0, sby_act}, 32'h1);
      for (int i = 0; i < 6; i++) chk({22'h0, code[i]}, 32'h0);
      bus(1'b0, 5'h04, 32'h0);
      chk(rd, 32'h14);
      bus(1'b1, 5'h00, 32'h2);
      repeat (3) @(posedge i_sys_clk);
      chk({31'h0, sby_act}, 32'h0);
   endtask : t_regs
   task automatic t_standby();
      u_proc.pins(1'b0, 1'b1);
      chk({31'h0, sby_act}, 32'h1);
      for (int i = 0; i < 6; i++) chk({22'h0, code[i]}, 32'h0);
      chk({31'h0, loading}, 32'h0);
      t_frame(1'b1, 1'b1, 10'h0A5, 1'b0);
   endtask : t_standby
   task automatic test_done();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : test_done
   initial begin
      i_sys_rst = 1'b1;
      avs_addr = 5'h00;
      avs_wdata = 32'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      repeat (6) @(posedge i_sys_clk);
      i_sys_rst <= 1'b0;
      @(posedge i_sys_clk);
      t_frame(1'b1, 1'b1, 10'h000, 1'b0);
      t_frame(1'b1, 1'b0, 10'h3FA, 1'b1);
      t_frame(1'b0, 1'b1, 10'h155, 1'b1);
      t_frame(1'b0, 1'b0, 10'h2A0, 1'b0);
      t_standby();
      t_regs();
      test_done();
   end
   initial begin
      repeat (20000) @(posedge i_sys_clk);
      bad_count++;
      test_done();
   end
endmodule : tb_top
`default_nettype wire
